// ### inc/cdg_pkg.sv
package cdg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_OFS = 8'h00;
    localparam logic [7:0] CTRL1_OFS = 8'h04;
    localparam logic [7:0] RISE_OFS = 8'h08;
    localparam logic [7:0] FALL_OFS = 8'h0C;
    localparam logic [7:0] CTRL2_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C0_EN = 7;
    localparam int C0_OEB = 6;
    localparam int C0_OEA = 5;
    localparam int C0_POLB = 4;
    localparam int C0_POLA = 3;
    localparam int C0_CS = 0;
    localparam int C1_OVLB = 6;
    localparam int C1_OVLA = 4;
    localparam int C1_IS_LO = 0;
    localparam int C2_SHUT = 0;
    localparam int ST_A = 0;
    localparam int ST_B = 1;
    localparam int ST_IN = 2;
    localparam int ST_SHUT = 3;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int DB_W = 6;
    localparam int IS_W = 2;
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [DB_W-1:0] DB_RST = 6'h00;
    localparam logic [IS_W-1:0] IS_CMP1 = 2'h0;
    localparam logic [IS_W-1:0] IS_CMP2 = 2'h1;
    localparam logic [IS_W-1:0] IS_PWM1 = 2'h2;
    localparam logic [IS_W-1:0] IS_PWM2 = 2'h3;

    // Clock rates, for reference of dead-band timing
    localparam int MCLK_HZ = 40000000;
    localparam int HF_OSC_HZ = 16000000;

endpackage : cdg_pkg

// ### hw/cdg_complementary_waveform_generator.sv
// Contract
// - Two complementary drives A and B come from one of four input waveforms.
// - Two-bit input source select field in control_reg_1 picks the input.
// - Dead-band counting uses system clock or 16 MHz oscillator, one select bit.
// - Select bit one uses internal oscillator, zero uses system clock.
// - When module enable is set, both drives start cleared and inactive.
// - Output enable clear means the pin is not driven by this block.
// - Output enable set drives override level or active waveform.
// - Module enable clear makes enables and drive levels ineffective.
// - Polarity bit set gives active high, clear gives active low.
// - Polarity never alters the override levels.
// - In shutdown each pin drives its own override level bit.
// - Two independent 6-bit dead-band counters, rising and falling edge.
// - Dead band counts clock periods from zero up to register value.
// - Rising edge: B off at once, A on when rising count completes.
// - Rising count register sets interval over its full range.
// - Falling edge: A off at once, B on when falling count completes.
// - Falling count register sets interval over its full range.
// - Counting starts at the input edge; zero count inserts no dead time.
// - Input returning before count completes keeps waiting output off.
// - Delivered dead time may deviate by one dead-band clock period.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module cdg_complementary_waveform_generator #(
    parameter int DB_W = cdg_pkg::DB_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic comparator1_async_out,
    input wire logic comparator2_async_out,
    input wire logic pwm_ch1_out,
    input wire logic pwm_ch2_out,
    input wire logic internal_hf_osc,
    output logic output_a_drive,
    output logic output_a_oe,
    output logic output_b_drive,
    output logic output_b_oe
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] control_reg_0;
    logic [7:0] control_reg_1;
    logic [DB_W-1:0] rise_deadband_count;
    logic [DB_W-1:0] fall_deadband_count;
    logic shutdown_force;

    logic module_enable_bit;
    logic out_a_enable;
    logic out_b_enable;
    logic out_a_polarity;
    logic out_b_polarity;
    logic clock_source_select;
    logic out_a_override_level;
    logic out_b_override_level;
    logic [1:0] input_source_select;

    assign module_enable_bit = control_reg_0[cdg_pkg::C0_EN];
    assign out_b_enable = control_reg_0[cdg_pkg::C0_OEB];
    assign out_a_enable = control_reg_0[cdg_pkg::C0_OEA];
    assign out_b_polarity = control_reg_0[cdg_pkg::C0_POLB];
    assign out_a_polarity = control_reg_0[cdg_pkg::C0_POLA];
    assign clock_source_select = control_reg_0[cdg_pkg::C0_CS];
    assign out_b_override_level = control_reg_1[cdg_pkg::C1_OVLB];
    assign out_a_override_level = control_reg_1[cdg_pkg::C1_OVLA];
    assign input_source_select = control_reg_1[cdg_pkg::C1_IS_LO +: cdg_pkg::IS_W];

    logic drive_a_on;
    logic drive_b_on;
    logic sel_level;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            control_reg_0 <= cdg_pkg::CTRL0_RST;
            control_reg_1 <= cdg_pkg::CTRL1_RST;
            rise_deadband_count <= cdg_pkg::DB_RST;
            fall_deadband_count <= cdg_pkg::DB_RST;
            shutdown_force <= 1'b0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                cdg_pkg::CTRL0_OFS: control_reg_0 <= reg_wdata & 8'hF9;
                cdg_pkg::CTRL1_OFS: control_reg_1 <= reg_wdata & 8'h53;
                cdg_pkg::RISE_OFS: rise_deadband_count <= reg_wdata[DB_W-1:0];
                cdg_pkg::FALL_OFS: fall_deadband_count <= reg_wdata[DB_W-1:0];
                cdg_pkg::CTRL2_OFS: shutdown_force <= reg_wdata[cdg_pkg::C2_SHUT];
                default: ;
            endcase
        end
    end

    // Read data stands one cycle, zero otherwise
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                cdg_pkg::CTRL0_OFS: reg_rdata <= control_reg_0;
                cdg_pkg::CTRL1_OFS: reg_rdata <= control_reg_1;
                cdg_pkg::RISE_OFS: reg_rdata <= {{(8-DB_W){1'b0}}, rise_deadband_count};
                cdg_pkg::FALL_OFS: reg_rdata <= {{(8-DB_W){1'b0}}, fall_deadband_count};
                cdg_pkg::CTRL2_OFS: reg_rdata <= {7'h00, shutdown_force};
                cdg_pkg::STATUS_OFS: reg_rdata <= {4'h0, shutdown_force, sel_level,
                                                   drive_b_on, drive_a_on};
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Bit 4 is the oscillator pin; only stages 2 and 3 are inspected.
    logic [4:0] pin_raw;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] pin_level;

    assign pin_raw = {internal_hf_osc, pwm_ch2_out, pwm_ch1_out,
                      comparator2_async_out, comparator1_async_out};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    pin_level[gi] <= 1'b0;
                end
                else
                begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        pin_level[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Source and dead-band clock selection
    // ------------------------------------------------------------
    assign sel_level = pin_level[input_source_select];

    logic osc_rise;
    logic db_tick;

    // Oscillator half period is barely above one mclk period, so the
    // agreement filter would swallow whole phases; edges come from stages 2 and 3
    assign osc_rise = sync2[4] & ~sync3[4];

    // Oscillator rising edges become count ticks; mclk mode ticks every cycle
    assign db_tick = clock_source_select ? osc_rise : 1'b1;

    // ------------------------------------------------------------
    // Dead-band engine
    // ------------------------------------------------------------
    logic sel_prev;
    logic rise_edge;
    logic fall_edge;
    logic rise_busy;
    logic fall_busy;
    logic [DB_W-1:0] rise_cnt;
    logic [DB_W-1:0] fall_cnt;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sel_prev <= 1'b0;
        else
            sel_prev <= sel_level;
    end

    // Edges count only while enabled; stale level at enable is ignored
    assign rise_edge = module_enable_bit & sel_level & ~sel_prev;
    assign fall_edge = module_enable_bit & ~sel_level & sel_prev;

    // Rising counter; a falling edge abandons it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rise_busy <= 1'b0;
            rise_cnt <= '0;
        end
        else if (!module_enable_bit || fall_edge)
        begin
            rise_busy <= 1'b0;
            rise_cnt <= '0;
        end
        else if (rise_edge)
        begin
            rise_busy <= (rise_deadband_count != '0);
            rise_cnt <= '0;
        end
        else if (rise_busy && db_tick)
        begin
            // Tick phase vs. edge gives up to one period of error
            if (rise_cnt + 1'b1 == rise_deadband_count)
                rise_busy <= 1'b0;
            rise_cnt <= rise_cnt + 1'b1;
        end
    end

    // Falling counter; a rising edge abandons it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fall_busy <= 1'b0;
            fall_cnt <= '0;
        end
        else if (!module_enable_bit || rise_edge)
        begin
            fall_busy <= 1'b0;
            fall_cnt <= '0;
        end
        else if (fall_edge)
        begin
            fall_busy <= (fall_deadband_count != '0);
            fall_cnt <= '0;
        end
        else if (fall_busy && db_tick)
        begin
            if (fall_cnt + 1'b1 == fall_deadband_count)
                fall_busy <= 1'b0;
            fall_cnt <= fall_cnt + 1'b1;
        end
    end

    // Drive A
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            drive_a_on <= 1'b0;
        else if (!module_enable_bit)
            drive_a_on <= 1'b0;
        else if (fall_edge)
            drive_a_on <= 1'b0;
        else if (rise_edge && rise_deadband_count == '0)
            drive_a_on <= 1'b1;
        else if (rise_busy && db_tick && rise_cnt + 1'b1 == rise_deadband_count)
            drive_a_on <= 1'b1;
    end

    // Drive B
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            drive_b_on <= 1'b0;
        else if (!module_enable_bit)
            drive_b_on <= 1'b0;
        else if (rise_edge)
            drive_b_on <= 1'b0;
        else if (fall_edge && fall_deadband_count == '0)
            drive_b_on <= 1'b1;
        else if (fall_busy && db_tick && fall_cnt + 1'b1 == fall_deadband_count)
            drive_b_on <= 1'b1;
    end

    // ------------------------------------------------------------
    // Pin stage
    // ------------------------------------------------------------
    // Override bypasses polarity so safe levels stay what software wrote
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            output_a_drive <= 1'b0;
            output_b_drive <= 1'b0;
        end
        else if (!module_enable_bit)
        begin
            output_a_drive <= 1'b0;
            output_b_drive <= 1'b0;
        end
        else if (shutdown_force)
        begin
            output_a_drive <= out_a_override_level;
            output_b_drive <= out_b_override_level;
        end
        else
        begin
            output_a_drive <= out_a_polarity ? drive_a_on : ~drive_a_on;
            output_b_drive <= out_b_polarity ? drive_b_on : ~drive_b_on;
        end
    end

    assign output_a_oe = module_enable_bit & out_a_enable;
    assign output_b_oe = module_enable_bit & out_b_enable;

endmodule : cdg_complementary_waveform_generator

// ### tb/cdg_checker.sv
`timescale 1ns/1ps
module cdg_checker #(
    parameter int DB_W = 6
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic output_a_drive,
    input wire logic output_a_oe,
    input wire logic output_b_drive,
    input wire logic output_b_oe
);
    logic en, oea, oeb, pa, pb, ova, ovb, shut;
    logic [DB_W-1:0] rise, fall;
    logic [7:0] gapc;
    wire logic act_a = output_a_drive == pa;
    wire logic act_b = output_b_drive == pb;
    // Shadow of control bits, same edge as the block
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            {en, oeb, oea, pb, pa, ova, ovb, shut} <= '0;
            rise <= '0;
            fall <= '0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                cdg_pkg::CTRL0_OFS: {en, oeb, oea, pb, pa} <= reg_wdata[7:3];
                cdg_pkg::CTRL1_OFS: {ovb, ova} <= {reg_wdata[6], reg_wdata[4]};
                cdg_pkg::RISE_OFS: rise <= reg_wdata[DB_W-1:0];
                cdg_pkg::FALL_OFS: fall <= reg_wdata[DB_W-1:0];
                cdg_pkg::CTRL2_OFS: shut <= reg_wdata[0];
                default: ;
            endcase
        end
    end
    // Cycles with both switches off; saturates
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            gapc <= '0;
        else if (act_a || act_b)
            gapc <= '0;
        else if (gapc != 8'hFF)
            gapc <= gapc + 8'h01;
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_calm;
        (!act_a && !act_b) [*2];
    endsequence
    sequence s_shut;
        (en && shut) [*4];
    endsequence
    property p_oe_a;
        output_a_oe == (en && oea);
    endproperty
    property p_oe_b;
        output_b_oe == (en && oeb);
    endproperty
    property p_dis;
        (!en) [*2] |-> !output_a_drive && !output_b_drive;
    endproperty
    property p_start;
        $rose(en) |=> s_calm;
    endproperty
    property p_mutex;
        en && $past(en, 2) && !shut && !$past(shut, 2) |-> !(act_a && act_b);
    endproperty
    property p_ovr;
        s_shut |-> output_a_drive == ova && output_b_drive == ovb;
    endproperty
    property p_gap_r;
        $rose(act_a) && en && !shut |-> gapc >= 8'(rise);
    endproperty
    property p_gap_f;
        $rose(act_b) && en && !shut |-> gapc >= 8'(fall);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("oe a wrong");
    a_oe_b: assert property (p_oe_b) else $error("oe b wrong");
    a_dis: assert property (p_dis) else $error("drive while off");
    a_start: assert property (p_start) else $error("bad start");
    a_mutex: assert property (p_mutex) else $error("overlap");
    a_ovr: assert property (p_ovr) else $error("override wrong");
    a_gap_r: assert property (p_gap_r) else $error("rise gap short");
    a_gap_f: assert property (p_gap_f) else $error("fall gap short");
endmodule : cdg_checker

// ### tb/cdg_switch_model.sv
`timescale 1ns/1ps
module cdg_switch_model (
    input wire logic drive_a,
    input wire logic oe_a,
    input wire logic drive_b,
    input wire logic oe_b,
    output logic pin_a,
    output logic pin_b
);
    // Gate inputs have pull-downs, so a released pin reads low
    assign pin_a = oe_a ? drive_a : 1'b0;
    assign pin_b = oe_b ? drive_b : 1'b0;
endmodule : cdg_switch_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct {int rise; int fall; logic pa; logic pb;} cdg_row_s;
    cdg_row_s rows[4] = '{'{2, 3, 1, 1}, '{0, 5, 0, 1}, '{63, 0, 1, 0}, '{7, 1, 0, 0}};
    logic mclk, rst, reg_wr, reg_rd, osc, pa_r, pb_r, hit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0] src;
    logic output_a_drive, output_a_oe, output_b_drive, output_b_oe, pin_a, pin_b;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    cdg_complementary_waveform_generator #(
        .DB_W(cdg_pkg::DB_W)
    ) u_cdg_complementary_waveform_generator (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .comparator1_async_out(src[0]), .comparator2_async_out(src[1]),
        .pwm_ch1_out(src[2]), .pwm_ch2_out(src[3]), .internal_hf_osc(osc),
        .output_a_drive(output_a_drive), .output_a_oe(output_a_oe),
        .output_b_drive(output_b_drive), .output_b_oe(output_b_oe));
    cdg_switch_model u_cdg_switch_model (.drive_a(output_a_drive), .oe_a(output_a_oe),
        .drive_b(output_b_drive), .oe_b(output_b_oe), .pin_a(pin_a), .pin_b(pin_b));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Free-running 16 MHz oscillator, unrelated in phase
    initial
    begin
        osc = 1'b0;
        // Offset keeps oscillator edges off the mclk edges
        #3;
        forever #31.25 osc = ~osc;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            complete_run();
        end
    end
    task complete_run();
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] r, input logic [7:0] f);
        wr(cdg_pkg::CTRL0_OFS, 8'h00);
        wr(cdg_pkg::CTRL1_OFS, c1);
        wr(cdg_pkg::RISE_OFS, r);
        wr(cdg_pkg::FALL_OFS, f);
        wr(cdg_pkg::CTRL0_OFS, c0);
    endtask : cfg
    function automatic logic on(input logic b);
        return b ? (pin_b === pb_r) : (pin_a === pa_r);
    endfunction : on
    // Cycles from the old switch going off to the new one coming on
    task gap(input int s, input logic lvl, output int k);
        int t;
        @(posedge mclk) src[s] <= lvl;
        #1 t = 0;
        while (on(lvl) && t < 40)
        begin
            @(posedge mclk);
            #1 t++;
        end
        k = 0;
        while (!on(!lvl) && k < 200)
        begin
            @(posedge mclk);
            #1 k++;
        end
    endtask : gap
    initial
    begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata, src, pa_r, pb_r} = {3'h4, 20'h00000, 2'h3};
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        // Unselected sources held high to show they are ignored
        for (int i = 0; i < 4; i++)
        begin
            pa_r = rows[i].pa;
            pb_r = rows[i].pb;
            @(posedge mclk) src <= ~(4'h1 << i);
            cfg({3'h7, pb_r, pa_r, 3'h0}, 8'(i), 8'(rows[i].rise), 8'(rows[i].fall));
            gap(i, 1'b1, n);
            gap(i, 1'b0, n);
            gap(i, 1'b1, n);
            chk(8'(n), 8'(rows[i].rise), "rise gap");
            rd(cdg_pkg::STATUS_OFS, d);
            chk({5'h00, d[2:0]}, 8'h05, "status");
            gap(i, 1'b0, n);
            chk(8'(n), 8'(rows[i].fall), "fall gap");
        end
        pa_r = 1'b1;
        pb_r = 1'b1;
        @(posedge mclk) src <= 4'h0;
        cfg(8'hF8, 8'h00, 8'h14, 8'h02);
        gap(0, 1'b1, n);
        gap(0, 1'b0, n);
        @(posedge mclk) src[0] <= 1'b1;
        repeat (8) @(posedge mclk);
        src[0] <= 1'b0;
        hit = 1'b0;
        repeat (40)
        begin
            @(posedge mclk);
            #1 hit = hit | on(1'b0);
        end
        chk(8'(hit), 8'h00, "short pulse");
        chk(8'(on(1'b1)), 8'h01, "b back");
        cfg(8'hF9, 8'h00, 8'h04, 8'h04);
        gap(0, 1'b1, n);
        gap(0, 1'b0, n);
        gap(0, 1'b1, n);
        chk(8'(n >= 8 && n <= 13), 8'h01, "osc gap");
        cfg(8'hE0, 8'h10, 8'h01, 8'h01);
        wr(cdg_pkg::CTRL2_OFS, 8'h01);
        @(posedge mclk) src[0] <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 chk({6'h00, pin_a, pin_b}, 8'h02, "override");
        rd(cdg_pkg::CTRL1_OFS, d);
        chk(d, 8'h10, "ctrl1 readback");
        rd(8'h20, d);
        chk(d, 8'h00, "unmapped read");
        wr(cdg_pkg::CTRL0_OFS, 8'hA8);
        #1 chk({6'h00, output_a_oe, output_b_oe}, 8'h02, "oe");
        wr(cdg_pkg::CTRL0_OFS, 8'h60);
        repeat (2) @(posedge mclk);
        #1 chk({4'h0, output_a_oe, output_b_oe, pin_a, pin_b}, 8'h00, "disabled");
        wr(cdg_pkg::CTRL2_OFS, 8'h00);
        wr(cdg_pkg::CTRL0_OFS, 8'hF8);
        repeat (4) @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1 chk({output_a_drive, output_b_drive, output_a_oe, output_b_oe}, 8'h00, "reset out");
        rd(cdg_pkg::CTRL0_OFS, d);
        chk(d, 8'h00, "reset ctrl0");
        complete_run();
    end
endmodule : tb
bind cdg_complementary_waveform_generator cdg_checker #(.DB_W(DB_W)) u_cdg_checker (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .output_a_drive(output_a_drive), .output_a_oe(output_a_oe),
    .output_b_drive(output_b_drive), .output_b_oe(output_b_oe));
